//--- logic/atr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module atr_regs #(
   parameter int MS_CYCLES = atr_pkg::MS_CYCLES,
   parameter int SAMPLE_W = 24
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   output logic [31:0] regRdData,
   output logic regRdValid,
   output logic oscProdTrimSel,
   input wire logic oscTrimAck,
   input wire logic powerStageFault,
   output logic powerStageReset,
   output logic pwmEnable,
   output logic powerStageRestart,
   input wire logic [SAMPLE_W-1:0] serialLeftSample,
   input wire logic [SAMPLE_W-1:0] serialRightSample,
   output logic [SAMPLE_W-1:0] ch1Sample,
   output logic [SAMPLE_W-1:0] ch2Sample,
   output logic ch1ThreeStateMod,
   output logic ch2ThreeStateMod
);
   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   // recovery code to milliseconds
   function automatic logic [10:0] recov_ms(input logic [3:0] code);
      logic [10:0] ms;
      ms = atr_pkg::MS_1496;
      unique case (code)
         4'h2: ms = atr_pkg::MS_299;
         4'h3: ms = atr_pkg::MS_449;
         4'h4: ms = atr_pkg::MS_598;
         4'h5: ms = atr_pkg::MS_748;
         4'h6: ms = atr_pkg::MS_898;
         4'h7: ms = atr_pkg::MS_1047;
         4'h8: ms = atr_pkg::MS_1197;
         4'h9: ms = atr_pkg::MS_1346;
         default: ms = atr_pkg::MS_1496;
      endcase
      return ms;
   endfunction : recov_ms

   // source code legality, shared by both channels
   function automatic logic src_ok(input logic [2:0] code);
      return (code == atr_pkg::SRC_LEFT) || (code == atr_pkg::SRC_RIGHT) || (code == atr_pkg::SRC_ZERO);
   endfunction : src_ok

   // sample picked by a source code
   function automatic logic [SAMPLE_W-1:0] src_pick(input logic [2:0] code,
      input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] r);
      logic [SAMPLE_W-1:0] s;
      s = '0;
      if (code == atr_pkg::SRC_LEFT)
      begin
         s = l;
      end
      else if (code == atr_pkg::SRC_RIGHT)
      begin
         s = r;
      end
      return s;
   endfunction : src_pick

   ////////////////////////////////////////////////////////////////////////
   // state
   logic trimSel_r;
   logic trimPending_r;
   logic trimDone_r;
   logic ackS1_r;
   logic ackS2_r;
   logic ackS3_r;
   logic ackLvl_r;
   logic [3:0] recov_r;
   logic recovLocked_r;
   logic [31:0] route_r;
   logic [31:0] rdData_r;
   logic rdValid_r;
   logic [SAMPLE_W-1:0] ch1_r;
   logic [SAMPLE_W-1:0] ch2_r;
   atr_pkg::atr_ps_e ps_r;
   atr_pkg::atr_ps_e ps_nxt;

   // write decode
   logic wrTrim;
   logic wrRecov;
   logic wrRoute;
   logic recovCodeOk;
   logic takeRecov;
   logic trimReq;
   logic trimSet;
   logic trimDone_nxt;
   logic [2:0] ch1SrcWr;
   logic [2:0] ch2SrcWr;
   logic [31:0] route_nxt;
   logic [7:0] trimRd;
   logic [31:0] rdMux;
   logic timerStart;
   logic timerBusy;
   logic timerDone;

   assign wrTrim = regWrEn && (regAddr == atr_pkg::OFS_TRIM);
   assign wrRecov = regWrEn && (regAddr == atr_pkg::OFS_RECOV);
   assign wrRoute = regWrEn && (regAddr == atr_pkg::OFS_ROUTE);

   ////////////////////////////////////////////////////////////////////////
   // oscillator trim
   // a write with bit 1 low requests the production trim
   assign trimReq = wrTrim && !regWrData[atr_pkg::TRIM_SEL_BIT];
   // ack comes from the analog oscillator, a level that counts once stages two and three agree
   assign trimSet = trimPending_r && ackLvl_r && !trimReq;
   // a completion in the same cycle as a clearing write still lands
   assign trimDone_nxt = (trimSet || (trimPending_r && ackLvl_r)) ? 1'b1 :
                         (wrTrim ? 1'b0 : trimDone_r);
   assign oscProdTrimSel = !trimSel_r;
   assign trimRd = atr_pkg::TRIM_FIXED | (8'(trimDone_r) << atr_pkg::TRIM_DONE_BIT) |
                   (8'(trimSel_r) << atr_pkg::TRIM_SEL_BIT);

   // three-stage synchroniser, stage one feeds stage two only
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         ackS1_r <= 1'b0;
         ackS2_r <= 1'b0;
         ackS3_r <= 1'b0;
         ackLvl_r <= 1'b0;
      end
      else
      begin
         ackS1_r <= oscTrimAck;
         ackS2_r <= ackS1_r;
         ackS3_r <= ackS2_r;
         ackLvl_r <= (ackS2_r == ackS3_r) ? ackS3_r : ackLvl_r;
      end
   end

   // trim select, pending request and done flag
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         trimSel_r <= atr_pkg::TRIM_SEL_RST;
         trimPending_r <= 1'b0;
         trimDone_r <= 1'b0;
      end
      else
      begin
         trimSel_r <= wrTrim ? regWrData[atr_pkg::TRIM_SEL_BIT] : trimSel_r;
         trimPending_r <= trimReq ? 1'b1 : (wrTrim ? 1'b0 : trimPending_r);
         trimDone_r <= trimDone_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fault recovery period, write once, reserved codes refused
   assign recovCodeOk = (regWrData[7:4] == 4'h0) && (regWrData[3:0] >= atr_pkg::RECOV_MIN);
   // a refused code does not use up the single write
   assign takeRecov = wrRecov && recovCodeOk && !recovLocked_r;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         recov_r <= atr_pkg::RECOV_RST;
         recovLocked_r <= 1'b0;
      end
      else if (takeRecov)
      begin
         recov_r <= regWrData[3:0];
         recovLocked_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power stage supervision
   // every fault (re)starts the wait, also one arriving while waiting
   assign timerStart = powerStageFault;

   always_comb
   begin
      ps_nxt = ps_r;
      unique case (ps_r)
         atr_pkg::PS_RUN:
         begin
            if (powerStageFault)
            begin
               ps_nxt = atr_pkg::PS_WAIT;
            end
         end
         atr_pkg::PS_WAIT:
         begin
            if (timerDone && !powerStageFault)
            begin
               ps_nxt = atr_pkg::PS_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         ps_r <= atr_pkg::PS_RUN;
      end
      else
      begin
         ps_r <= ps_nxt;
      end
   end

   assign powerStageReset = (ps_r == atr_pkg::PS_WAIT);
   assign pwmEnable = (ps_r == atr_pkg::PS_RUN);
   assign powerStageRestart = timerDone && (ps_r == atr_pkg::PS_WAIT) && !powerStageFault;

   atr_recovery_timer #(
      .MS_CYCLES(MS_CYCLES)
   ) uTimer (
      .mclk(mclk),
      .nrst(nrst),
      .start(timerStart),
      .msCount(recov_ms(recov_r)),
      .busy(timerBusy),
      .done(timerDone)
   );

   ////////////////////////////////////////////////////////////////////////
   // input route and modulation
   assign ch1SrcWr = regWrData[atr_pkg::CH1_SRC_LSB +: 3];
   assign ch2SrcWr = regWrData[atr_pkg::CH2_SRC_LSB +: 3];
   // reserved source codes keep the old route; reserved fields hold their pattern
   assign route_nxt = {route_r[31:24],
                       regWrData[atr_pkg::CH1_MOD_BIT],
                       src_ok(ch1SrcWr) ? ch1SrcWr : route_r[atr_pkg::CH1_SRC_LSB +: 3],
                       regWrData[atr_pkg::CH2_MOD_BIT],
                       src_ok(ch2SrcWr) ? ch2SrcWr : route_r[atr_pkg::CH2_SRC_LSB +: 3],
                       route_r[15:0]};
   assign ch1ThreeStateMod = route_r[atr_pkg::CH1_MOD_BIT];
   assign ch2ThreeStateMod = route_r[atr_pkg::CH2_MOD_BIT];
   assign ch1Sample = ch1_r;
   assign ch2Sample = ch2_r;

   // route register and registered channel samples
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         route_r <= atr_pkg::ROUTE_RST;
         ch1_r <= '0;
         ch2_r <= '0;
      end
      else
      begin
         route_r <= wrRoute ? route_nxt : route_r;
         ch1_r <= src_pick(route_r[atr_pkg::CH1_SRC_LSB +: 3], serialLeftSample, serialRightSample);
         ch2_r <= src_pick(route_r[atr_pkg::CH2_SRC_LSB +: 3], serialLeftSample, serialRightSample);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port, unmapped addresses read zero
   assign rdMux = (regAddr == atr_pkg::OFS_TRIM) ? {24'h0, trimRd} :
                  (regAddr == atr_pkg::OFS_RECOV) ? {28'h0, recov_r} :
                  (regAddr == atr_pkg::OFS_ROUTE) ? route_r : 32'h0;
   assign regRdData = rdData_r;
   assign regRdValid = rdValid_r;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         rdData_r <= '0;
         rdValid_r <= 1'b0;
      end
      else
      begin
         rdData_r <= regRdEn ? rdMux : rdData_r;
         rdValid_r <= regRdEn;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   zeroTrim_a: assert property (@(posedge mclk) disable iff (!nrst)
      (wrTrim && regWrData == 32'h0) |=> oscProdTrimSel && trimPending_r)
      else $error("zero write did not select production trim");
   doneCause_a: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(trimDone_r) |-> $past(trimPending_r) && $past(ackLvl_r))
      else $error("trim done without completed request");
   doneRead_a: assert property (@(posedge mclk) disable iff (!nrst)
      (regRdEn && regAddr == atr_pkg::OFS_TRIM) |=> regRdData[atr_pkg::TRIM_DONE_BIT] == $past(trimDone_r))
      else $error("trim done bit misread");
   trimSelBit_a: assert property (@(posedge mclk) disable iff (!nrst)
      wrTrim |=> trimSel_r == $past(regWrData[atr_pkg::TRIM_SEL_BIT]))
      else $error("trim select bit not stored");
   faultHalt_a: assert property (@(posedge mclk) disable iff (!nrst)
      powerStageFault |=> powerStageReset && !pwmEnable && timerBusy)
      else $error("fault did not halt the power stage");
   restartEnd_a: assert property (@(posedge mclk) disable iff (!nrst)
      powerStageRestart |=> pwmEnable && !powerStageReset)
      else $error("restart did not release the power stage");
   recovLegal_a: assert property (@(posedge mclk) disable iff (!nrst)
      recov_r >= atr_pkg::RECOV_MIN)
      else $error("reserved recovery code taken");
   recovOnce_a: assert property (@(posedge mclk) disable iff (!nrst)
      recovLocked_r |=> $stable(recov_r) && recovLocked_r)
      else $error("recovery period changed after lock");
   ch1Zero_a: assert property (@(posedge mclk) disable iff (!nrst)
      (route_r[atr_pkg::CH1_SRC_LSB +: 3] == atr_pkg::SRC_ZERO) |=> ch1Sample == '0)
      else $error("channel 1 not grounded");
   ch2Right_a: assert property (@(posedge mclk) disable iff (!nrst)
      (route_r[atr_pkg::CH2_SRC_LSB +: 3] == atr_pkg::SRC_RIGHT) |=> ch2Sample == $past(serialRightSample))
      else $error("channel 2 not routed right");
   modBits_a: assert property (@(posedge mclk) disable iff (!nrst)
      wrRoute |=> ch1ThreeStateMod == $past(regWrData[atr_pkg::CH1_MOD_BIT])
                  && ch2ThreeStateMod == $past(regWrData[atr_pkg::CH2_MOD_BIT]))
      else $error("modulation select not taken");
endmodule : atr_regs
`default_nettype wire

//--- logic/atr_pkg.sv
// Contract
// - writing 0x00 to the trim register selects the production oscillator trim
// - trim bit 6 reads 1 once trim completed, 0 otherwise and at reset
// - trim bit 1 written 0 selects production trim; resets to 1
// - a power stage fault resets the power stage and halts all pwm
// - after a fault, wait the programmed period, then restart the power stage
// - codes 0010..0101 give 299, 449, 598, 748 ms; 0010 is default
// - codes 0110..1001 give 898, 1047, 1197, 1346 ms
// - codes 1010, 1011 and 11xx give 1496 ms
// - reserved recovery codes are never written by software nor taken up
// - recovery register takes one write per reset; later writes are ignored
// - mux bit 23 / bit 19 pick channel 1 / 2 modulation, 0 default
// - mux bits 22:20: 000 left (default), 001 right, 110 zero; others reserved
// - mux bits 18:16: 000 left, 001 right (default), 110 zero; others reserved
`default_nettype none
package atr_pkg;
   // register map
   localparam logic [7:0] OFS_TRIM = 8'h1b;
   localparam logic [7:0] OFS_RECOV = 8'h1c;
   localparam logic [7:0] OFS_ROUTE = 8'h20;
   // trim register layout
   localparam int TRIM_DONE_BIT = 6;
   localparam int TRIM_SEL_BIT = 1;
   localparam logic [7:0] TRIM_FIXED = 8'h80;
   localparam logic TRIM_SEL_RST = 1'b1;
   // recovery register
   localparam logic [3:0] RECOV_RST = 4'h2;
   localparam logic [3:0] RECOV_MIN = 4'h2;
   // route register layout
   localparam int CH1_MOD_BIT = 23;
   localparam int CH2_MOD_BIT = 19;
   localparam int CH1_SRC_LSB = 20;
   localparam int CH2_SRC_LSB = 16;
   localparam logic [31:0] ROUTE_RST = 32'h0001_7772;
   localparam logic [31:0] ROUTE_LIVE = 32'h00ff_0000;
   localparam logic [2:0] SRC_LEFT = 3'h0;
   localparam logic [2:0] SRC_RIGHT = 3'h1;
   localparam logic [2:0] SRC_ZERO = 3'h6;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int MS_CYCLES = CLK_HZ / 1000;
   localparam logic [10:0] MS_299 = 11'd299;
   localparam logic [10:0] MS_449 = 11'd449;
   localparam logic [10:0] MS_598 = 11'd598;
   localparam logic [10:0] MS_748 = 11'd748;
   localparam logic [10:0] MS_898 = 11'd898;
   localparam logic [10:0] MS_1047 = 11'd1047;
   localparam logic [10:0] MS_1197 = 11'd1197;
   localparam logic [10:0] MS_1346 = 11'd1346;
   localparam logic [10:0] MS_1496 = 11'd1496;
   typedef enum logic [0:0] {PS_RUN, PS_WAIT} atr_ps_e;
endpackage : atr_pkg
`default_nettype wire

//--- logic/atr_recovery_timer.sv
`timescale 1ns/1ps
`default_nettype none
module atr_recovery_timer #(
   parameter int MS_CYCLES = atr_pkg::MS_CYCLES
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic start,
   input wire logic [10:0] msCount,
   output logic busy,
   output logic done
);
   localparam int PW = $clog2(MS_CYCLES + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYCLES - 1);

   logic [PW-1:0] pre_r;
   logic [10:0] ms_r;
   logic busy_r;
   logic msTick;
   logic lastMs;

   // a millisecond prescaler keeps the long wait cheap in flops
   assign msTick = busy_r && (pre_r == PRE_LAST);
   assign lastMs = (ms_r + 11'd1 == msCount);
   assign busy = busy_r;
   assign done = msTick && lastMs;

   ////////////////////////////////////////////////////////////////////////
   // restart by start even while busy, so a repeat fault re-arms the wait
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         pre_r <= '0;
         ms_r <= '0;
         busy_r <= 1'b0;
      end
      else if (start)
      begin
         pre_r <= '0;
         ms_r <= '0;
         busy_r <= 1'b1;
      end
      else if (busy_r)
      begin
         pre_r <= msTick ? '0 : pre_r + PW'(1);
         ms_r <= msTick ? ms_r + 11'd1 : ms_r;
         busy_r <= !(msTick && lastMs);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // wait ends exactly on the programmed count of milliseconds
   doneCount_a: assert property (@(posedge mclk) disable iff (!nrst)
      done |-> (ms_r == msCount - 11'd1) && (pre_r == PRE_LAST))
      else $error("recovery done at wrong count");
   idleQuiet_a: assert property (@(posedge mclk) disable iff (!nrst)
      (!busy_r && !start) |=> !busy_r && !done)
      else $error("timer ran without a start");
endmodule : atr_recovery_timer
`default_nettype wire

//--- bench/tb_amp_trim_recovery_input_route.sv
`timescale 1ns/1ps
`default_nettype none
module tb_amp_trim_recovery_input_route;
   // short ms so all fourteen recovery waits fit in one run
   localparam int MSC = 4;
   logic mclk, nrst, regWrEn, regRdEn, oscTrimAck, powerStageFault;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData, rdv;
   logic regRdValid, oscProdTrimSel, powerStageReset, pwmEnable, powerStageRestart;
   logic [23:0] serialLeftSample, serialRightSample, ch1Sample, ch2Sample;
   logic ch1ThreeStateMod, ch2ThreeStateMod;
   int errorCnt = 0;
   int nCompared = 0;

   atr_regs #(.MS_CYCLES(MSC), .SAMPLE_W(24)) uut (.mclk(mclk), .nrst(nrst), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .regRdValid(regRdValid), .oscProdTrimSel(oscProdTrimSel), .oscTrimAck(oscTrimAck),
      .powerStageFault(powerStageFault), .powerStageReset(powerStageReset), .pwmEnable(pwmEnable),
      .powerStageRestart(powerStageRestart), .serialLeftSample(serialLeftSample),
      .serialRightSample(serialRightSample), .ch1Sample(ch1Sample), .ch2Sample(ch2Sample),
      .ch1ThreeStateMod(ch1ThreeStateMod), .ch2ThreeStateMod(ch2ThreeStateMod));

   ////////////////////////////////////////////////////////////////////////////////
   // clock and watchdog, the limit leaves margin over the expected run of about 70k cycles
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial
   begin
      repeat (90000) @(posedge mclk);
      errorCnt++;
      stopTest();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // shared tasks, all inputs change on the falling edge
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      nCompared++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk
   task automatic stopTest();
      if (errorCnt == 0 && nCompared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stopTest
   task automatic doReset();
      @(negedge mclk);
      nrst = 1'b0;
      repeat (12) @(negedge mclk);
      nrst = 1'b1;
   endtask : doReset
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge mclk);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      @(negedge mclk);
      regWrEn = 1'b0;
   endtask : wr
   // read strobe lasts one cycle; valid is looked at in the cycle after it
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(negedge mclk);
      regRdEn = 1'b1;
      regAddr = a;
      @(negedge mclk);
      regRdEn = 1'b0;
      chk({31'h0, regRdValid}, 32'h1, "read valid");
      chk(regRdData, exp, what);
   endtask : rdChk

   ////////////////////////////////////////////////////////////////////////////////
   // expectations
   function automatic int msOf(input int code);
      case (code)
         2: return 299;
         3: return 449;
         4: return 598;
         5: return 748;
         6: return 898;
         7: return 1047;
         8: return 1197;
         9: return 1346;
         default: return 1496;
      endcase
   endfunction : msOf
   function automatic logic [23:0] pick(input logic [2:0] s, input logic [23:0] l, input logic [23:0] r);
      return (s == 3'h0) ? l : (s == 3'h1) ? r : 24'h0;
   endfunction : pick

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin : mainSeq
      logic [2:0] c1, c2, s1, s2;
      logic m1, m2;
      int k, n;
      nrst = 1'b0;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 8'h00;
      regWrData = 32'h0;
      oscTrimAck = 1'b0;
      powerStageFault = 1'b0;
      serialLeftSample = 24'h0;
      serialRightSample = 24'h0;
      void'($urandom(55059));
      doReset();
      // defaults after reset
      rdChk(atr_pkg::OFS_TRIM, 32'h82, "trim reset");
      rdChk(atr_pkg::OFS_RECOV, 32'h2, "recovery reset");
      rdChk(atr_pkg::OFS_ROUTE, 32'h0001_7772, "route reset");
      chk({31'h0, pwmEnable}, 32'h1, "pwm after reset");
      wr(8'h21, $urandom);
      rdChk(8'h21, 32'h0, "unmapped read");
      // trim: production select, done only after the oscillator answers
      wr(atr_pkg::OFS_TRIM, 32'h0);
      chk({31'h0, oscProdTrimSel}, 32'h1, "trim select");
      rdChk(atr_pkg::OFS_TRIM, 32'h80, "trim pending");
      oscTrimAck = 1'b1;
      repeat (10) @(negedge mclk);
      rdChk(atr_pkg::OFS_TRIM, 32'hc0, "trim done");
      // a stale acknowledge after reset must not set done again
      doReset();
      rdChk(atr_pkg::OFS_TRIM, 32'h82, "trim done cleared");
      wr(atr_pkg::OFS_TRIM, 32'hff);
      chk({31'h0, oscProdTrimSel}, 32'h0, "trim deselect");
      rdChk(atr_pkg::OFS_TRIM, 32'h82, "trim read only bits");
      oscTrimAck = 1'b0;
      // routing: every code on both channels, then random ones
      s1 = 3'h0;
      s2 = 3'h1;
      for (int i = 0; i < 24; i++)
      begin
         c1 = (i < 8) ? 3'(i) : 3'($urandom);
         c2 = (i < 8) ? 3'(7 - i) : 3'($urandom);
         m1 = 1'($urandom);
         m2 = 1'($urandom);
         serialLeftSample = 24'($urandom);
         serialRightSample = 24'($urandom);
         // reserved fields carry their reset pattern; interchannel delay lives outside this block
         wr(atr_pkg::OFS_ROUTE, {8'h00, m1, c1, m2, c2, 16'h7772});
         if (c1 == 3'h0 || c1 == 3'h1 || c1 == 3'h6)
            s1 = c1;
         if (c2 == 3'h0 || c2 == 3'h1 || c2 == 3'h6)
            s2 = c2;
         repeat (2) @(negedge mclk);
         chk({8'h0, ch1Sample}, {8'h0, pick(s1, serialLeftSample, serialRightSample)}, "ch1 sample");
         chk({8'h0, ch2Sample}, {8'h0, pick(s2, serialLeftSample, serialRightSample)}, "ch2 sample");
         chk({30'h0, ch1ThreeStateMod, ch2ThreeStateMod}, {30'h0, m1, m2}, "modulation");
         rdChk(atr_pkg::OFS_ROUTE, {8'h0, m1, s1, m2, s2, 16'h7772}, "route read");
      end
      // recovery: refusals, single write, then the wait length for each code
      for (int c = 2; c < 16; c++)
      begin
         doReset();
         wr(atr_pkg::OFS_RECOV, 32'hf0 | 32'(c));
         wr(atr_pkg::OFS_RECOV, 32'h1);
         rdChk(atr_pkg::OFS_RECOV, 32'h2, "reserved code refused");
         wr(atr_pkg::OFS_RECOV, 32'(c));
         wr(atr_pkg::OFS_RECOV, (c == 2) ? 32'h3 : 32'h2);
         rdChk(atr_pkg::OFS_RECOV, 32'(c), "single write");
         n = msOf(c) * MSC;
         @(negedge mclk);
         powerStageFault = 1'b1;
         @(negedge mclk);
         powerStageFault = 1'b0;
         chk({30'h0, powerStageReset, pwmEnable}, 32'h2, "fault halts pwm");
         k = 1;
         while (powerStageRestart !== 1'b1 && k < 8000)
         begin
            @(negedge mclk);
            k++;
         end
         // the wait is exact to the cycle, yet allow two cycles either way
         chk({31'h0, 1'(k >= n - 2 && k <= n + 2)}, 32'h1, "recovery wait length");
         @(negedge mclk);
         chk({29'h0, powerStageRestart, powerStageReset, pwmEnable}, 32'h1, "restart pulse");
      end
      // a second fault inside the wait starts the full wait over
      @(negedge mclk);
      powerStageFault = 1'b1;
      @(negedge mclk);
      powerStageFault = 1'b0;
      repeat (99) @(negedge mclk);
      powerStageFault = 1'b1;
      @(negedge mclk);
      powerStageFault = 1'b0;
      k = 1;
      while (powerStageRestart !== 1'b1 && k < 8000)
      begin
         @(negedge mclk);
         k++;
      end
      chk(32'(k), 32'(n), "wait restarted by repeat fault");
      stopTest();
   end : mainSeq
endmodule : tb_amp_trim_recovery_input_route
`default_nettype wire
